// *** hw/period_timer_pkg.sv ***
// Function
// - 8-bit count register, reset to zero
// - Fosc/4 through 1:1/1:4/1:16 prescaler
// - Postscaler 1..16 sets match flag bit 1
// - Count or control write clears scalers
// - Control write keeps count value
// - Count to period, then wrap to zero
// - 8-bit period register, reset to FFh
// - Run bit 2 gates counting
// - Match event drives PWM time base
// - Postscaler select bits 6:3, bit7 zero
// - Flag sets regardless of enables
`default_nettype none
package period_timer_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_INT_CTRL   = 8'h0B;
    localparam logic [7:0] ADDR_INT_CTRL_H = 8'h8B;
    localparam logic [7:0] ADDR_PERIPH_FLG = 8'h0C;
    localparam logic [7:0] ADDR_TIMER_CNT  = 8'h11;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h12;
    localparam logic [7:0] ADDR_PERIPH_EN  = 8'h8C;
    localparam logic [7:0] ADDR_PERIOD     = 8'h92;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int CTRL_RUN_BIT   = 2;
    localparam int CTRL_PS_LSB    = 3;
    localparam int CTRL_PS_MSB    = 6;
    localparam int MATCH_BIT      = 1;
    localparam int GLOBAL_GATE_BIT = 7;
    localparam int PERIPH_GATE_BIT = 6;
    localparam logic [7:0] CTRL_MASK     = 8'h7F;
    localparam logic [7:0] CNT_RESET     = 8'h00;
    localparam logic [7:0] PERIOD_RESET  = 8'hFF;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] REG_ZERO      = 8'h00;
    localparam logic [1:0] CLK_DIV_LAST  = 2'h3;
    localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
    localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;
    localparam logic [3:0] PRE_LAST_DIV1  = 4'h0;
    localparam logic [3:0] SCALER_RESET   = 4'h0;
    localparam logic [1:0] CLK_DIV_RESET  = 2'h0;
endpackage
`default_nettype wire

// *** hw/period_timer_8bit.sv ***
`timescale 1ns/100ps
`default_nettype none
module period_timer_8bit
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic            o_pwm_base,
    output logic            o_irq
);
    // ****************************************
    // State
    // ****************************************
    logic [7:0] cnt_q,  cnt_d;
    logic [7:0] per_q,  per_d;
    logic [6:0] ctl_q,  ctl_d;
    logic [7:0] ictl_q, ictl_d;
    logic       flg_q,  flg_d;
    logic       ena_q,  ena_d;
    logic [1:0] cdiv_q, cdiv_d;
    logic [3:0] pre_q,  pre_d;
    logic [3:0] post_q, post_d;
    logic       pwm_q,  pwm_d;
    logic       irq_q,  irq_d;
    logic [7:0] rd_q,   rd_d;

    logic wr_cnt, wr_ctl, wr_flg, wr_ictl, wr_en, wr_per;
    logic inst_tick, pre_tick, step, match;
    logic [3:0] pre_last;

    assign wr_cnt  = i_wr && i_addr == period_timer_pkg::ADDR_TIMER_CNT;
    assign wr_ctl  = i_wr && i_addr == period_timer_pkg::ADDR_TIMER_CTRL;
    assign wr_flg  = i_wr && i_addr == period_timer_pkg::ADDR_PERIPH_FLG;
    assign wr_en   = i_wr && i_addr == period_timer_pkg::ADDR_PERIPH_EN;
    assign wr_per  = i_wr && i_addr == period_timer_pkg::ADDR_PERIOD;
    assign wr_ictl = i_wr && (i_addr == period_timer_pkg::ADDR_INT_CTRL
                           || i_addr == period_timer_pkg::ADDR_INT_CTRL_H);

    // ****************************************
    // Time base
    // ****************************************
    // Instruction clock is i_clk / 4, one-cycle enable
    assign inst_tick = cdiv_q == period_timer_pkg::CLK_DIV_LAST;

    always_comb
    begin
        unique case (ctl_q[1:0])
            2'h0:    pre_last = period_timer_pkg::PRE_LAST_DIV1;
            2'h1:    pre_last = period_timer_pkg::PRE_LAST_DIV4;
            default: pre_last = period_timer_pkg::PRE_LAST_DIV16;
        endcase
    end

    assign pre_tick = inst_tick && ctl_q[period_timer_pkg::CTRL_RUN_BIT]
                      && pre_q == pre_last;
    // Control write restarts the scalers, so it swallows a tick
    assign step     = pre_tick && !wr_ctl;
    assign match    = step && cnt_q == per_q;

    always_comb
    begin
        cdiv_d = cdiv_q + 2'h1;
        pre_d  = pre_q;
        cnt_d  = cnt_q;
        post_d = post_q;
        if (inst_tick && ctl_q[period_timer_pkg::CTRL_RUN_BIT])
            pre_d = (pre_q == pre_last) ? 4'h0 : pre_q + 4'h1;
        if (step)
            cnt_d = match ? period_timer_pkg::CNT_RESET : cnt_q + 8'h1;
        if (match)
            post_d = (post_q == ctl_q[period_timer_pkg::CTRL_PS_MSB:period_timer_pkg::CTRL_PS_LSB])
                     ? 4'h0 : post_q + 4'h1;
        if (wr_cnt)
            cnt_d = i_wdata;
        // Control write clears scalers but leaves the count alone
        if (wr_cnt || wr_ctl)
        begin
            pre_d  = 4'h0;
            post_d = 4'h0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_comb
    begin
        per_d  = wr_per ? i_wdata : per_q;
        ctl_d  = wr_ctl ? i_wdata[6:0] : ctl_q;
        ictl_d = wr_ictl ? i_wdata : ictl_q;
        ena_d  = wr_en ? i_wdata[period_timer_pkg::MATCH_BIT] : ena_q;
        flg_d  = wr_flg ? i_wdata[period_timer_pkg::MATCH_BIT] : flg_q;
        // Set wins over a same-cycle software clear
        if (match && post_q == ctl_q[period_timer_pkg::CTRL_PS_MSB:period_timer_pkg::CTRL_PS_LSB]
            && !wr_ctl)
            flg_d = 1'b1;
    end

    // ****************************************
    // Outputs and read port
    // ****************************************
    always_comb
    begin
        pwm_d  = match;
        irq_d  = flg_q && ena_q && ictl_q[period_timer_pkg::PERIPH_GATE_BIT]
                 && ictl_q[period_timer_pkg::GLOBAL_GATE_BIT];
        rd_d   = period_timer_pkg::REG_ZERO;
        if (i_rd)
        begin
            if (i_addr == period_timer_pkg::ADDR_TIMER_CNT)
                rd_d = cnt_q;
            else if (i_addr == period_timer_pkg::ADDR_PERIOD)
                rd_d = per_q;
            else if (i_addr == period_timer_pkg::ADDR_TIMER_CTRL)
                rd_d = {1'b0, ctl_q} & period_timer_pkg::CTRL_MASK;
            else if (i_addr == period_timer_pkg::ADDR_PERIPH_FLG)
                rd_d = {6'h00, flg_q, 1'b0};
            else if (i_addr == period_timer_pkg::ADDR_PERIPH_EN)
                rd_d = {6'h00, ena_q, 1'b0};
            else if (i_addr == period_timer_pkg::ADDR_INT_CTRL
                     || i_addr == period_timer_pkg::ADDR_INT_CTRL_H)
                rd_d = ictl_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_q  <= period_timer_pkg::CNT_RESET;
            cdiv_q <= period_timer_pkg::CLK_DIV_RESET;
            pre_q  <= period_timer_pkg::SCALER_RESET;
            post_q <= period_timer_pkg::SCALER_RESET;
        end
        else
        begin
            cnt_q  <= cnt_d;
            cdiv_q <= cdiv_d;
            pre_q  <= pre_d;
            post_q <= post_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            per_q  <= period_timer_pkg::PERIOD_RESET;
            ctl_q  <= period_timer_pkg::CTRL_RESET[6:0];
            ictl_q <= period_timer_pkg::REG_ZERO;
            flg_q  <= 1'b0;
            ena_q  <= 1'b0;
        end
        else
        begin
            per_q  <= per_d;
            ctl_q  <= ctl_d;
            ictl_q <= ictl_d;
            flg_q  <= flg_d;
            ena_q  <= ena_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pwm_q  <= 1'b0;
            irq_q  <= 1'b0;
            rd_q   <= period_timer_pkg::REG_ZERO;
        end
        else
        begin
            pwm_q  <= pwm_d;
            irq_q  <= irq_d;
            rd_q   <= rd_d;
        end
    end

    assign o_rdata    = rd_q;
    assign o_pwm_base = pwm_q;
    assign o_irq      = irq_q;

    // ****************************************
    // Checks
    // ****************************************
    property p_wrap;
        @(posedge i_clk) disable iff (!i_rst_b)
        match && !wr_cnt |=> cnt_q == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap");

    property p_halt;
        @(posedge i_clk) disable iff (!i_rst_b)
        !ctl_q[period_timer_pkg::CTRL_RUN_BIT] && !wr_cnt |=> $stable(cnt_q);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved while halted");

    property p_ctl_keep;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_ctl |=> cnt_q == $past(cnt_q);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("control write changed count");

    property p_clr;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_cnt || wr_ctl |=> pre_q == 4'h0 && post_q == 4'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("scalers not cleared");

    property p_pwm;
        @(posedge i_clk) disable iff (!i_rst_b)
        match |=> o_pwm_base;
    endproperty
    a_pwm: assert property (p_pwm) else $error("no time base pulse");

    property p_bit7;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_rd && i_addr == period_timer_pkg::ADDR_TIMER_CTRL |=> !o_rdata[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("control bit 7 read one");

    property p_irq;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_irq |-> $past(flg_q) && $past(ena_q) && $past(ictl_q[period_timer_pkg::GLOBAL_GATE_BIT])
                  && $past(ictl_q[period_timer_pkg::PERIPH_GATE_BIT]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without all gates");

    property p_flag;
        @(posedge i_clk) disable iff (!i_rst_b)
        match && post_q == ctl_q[period_timer_pkg::CTRL_PS_MSB:period_timer_pkg::CTRL_PS_LSB] && !wr_ctl
        |=> flg_q;
    endproperty
    a_flag: assert property (p_flag) else $error("match flag not set");

    property p_pre1;
        @(posedge i_clk) disable iff (!i_rst_b)
        pre_tick && ctl_q[1:0] == 2'h0 && !wr_cnt && !wr_ctl ##1 !wr_cnt && !wr_ctl
        |-> ##3 pre_tick || !ctl_q[2] || ctl_q[1:0] != 2'h0;
    endproperty
    a_pre1: assert property (p_pre1) else $error("prescale 1:1 tick spacing");

    property p_wr_cnt;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_cnt |=> cnt_q == $past(i_wdata);
    endproperty
    a_wr_cnt: assert property (p_wr_cnt) else $error("count write lost");

    property p_rd_cnt;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_rd && i_addr == period_timer_pkg::ADDR_TIMER_CNT |=> o_rdata == $past(cnt_q);
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("count read wrong");

    property p_wr_per;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_per |=> per_q == $past(i_wdata);
    endproperty
    a_wr_per: assert property (p_wr_per) else $error("period write lost");

    property p_rd_per;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_rd && i_addr == period_timer_pkg::ADDR_PERIOD |=> o_rdata == $past(per_q);
    endproperty
    a_rd_per: assert property (p_rd_per) else $error("period read wrong");

    property p_rd_ctl;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_rd && i_addr == period_timer_pkg::ADDR_TIMER_CTRL |=> o_rdata == {1'b0, $past(ctl_q)};
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");

    property p_div4;
        @(posedge i_clk) disable iff (!i_rst_b)
        inst_tick |-> ##4 inst_tick;
    endproperty
    a_div4: assert property (p_div4) else $error("instruction tick spacing");

    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        !step && !wr_cnt |=> $stable(cnt_q);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without a tick");

    property p_inc;
        @(posedge i_clk) disable iff (!i_rst_b)
        step && !match && !wr_cnt |=> cnt_q == $past(cnt_q) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not step by one");

    property p_pre_range;
        @(posedge i_clk) disable iff (!i_rst_b)
        pre_q <= pre_last;
    endproperty
    a_pre_range: assert property (p_pre_range) else $error("prescaler past its end");

    property p_post_range;
        @(posedge i_clk) disable iff (!i_rst_b)
        post_q <= ctl_q[period_timer_pkg::CTRL_PS_MSB:period_timer_pkg::CTRL_PS_LSB];
    endproperty
    a_post_range: assert property (p_post_range) else $error("postscaler past its end");

    property p_flag_src;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(flg_q) |-> $past(match) || $past(wr_flg);
    endproperty
    a_flag_src: assert property (p_flag_src) else $error("flag set without a match");

    property p_flag_clr;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_flg && !i_wdata[period_timer_pkg::MATCH_BIT] && !match |=> !flg_q;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by software");

    property p_irq_on;
        @(posedge i_clk) disable iff (!i_rst_b)
        flg_q && ena_q && ictl_q[period_timer_pkg::PERIPH_GATE_BIT]
        && ictl_q[period_timer_pkg::GLOBAL_GATE_BIT] |=> o_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt missing");
endmodule
`default_nettype wire

// *** verification/period_timer_8bit_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module period_timer_8bit_tb;
    logic       i_clk;
    logic       i_rst_b;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] o_rdata;
    logic       o_pwm_base;
    logic       o_irq;
    int         err_count;
    int         checks_done;
    int         seed;
    int         c;
    int         k;
    logic [7:0] v;

    period_timer_8bit dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm_base(o_pwm_base), .o_irq(o_irq));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ****************************************
    // Bus tasks and expectations
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        chk(nm, {8'h00, e}, {8'h00, o_rdata});
    endtask

    // Clocks from one match pulse to the next, bounded
    task automatic meas(output int n);
        n = 0;
        do
        begin
            @(negedge i_clk);
            n++;
        end
        while (!o_pwm_base && n < 3000);
    endtask

    function automatic int gap(input int p, input int ps);
        return 4 * (p + 1) * ((ps == 0) ? 1 : (ps == 1) ? 4 : 16);
    endfunction

    task automatic test_done();
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #500000;
        err_count++;
        test_done();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {i_addr, i_wdata, i_wr, i_rd} = '0;
        err_count = 0;
        checks_done = 0;
        seed = 90;
        i_rst_b = 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(period_timer_pkg::ADDR_TIMER_CNT, 8'h00, "count");
        rd(period_timer_pkg::ADDR_PERIOD, 8'hFF, "period");
        rd(period_timer_pkg::ADDR_TIMER_CTRL, 8'h00, "control");
        wr(period_timer_pkg::ADDR_TIMER_CTRL, 8'hFF);
        rd(period_timer_pkg::ADDR_TIMER_CTRL, 8'h7F, "control");
        wr(8'h50, 8'hA5);
        rd(8'h50, 8'h00, "unmapped");
        v = 8'($random(seed));
        wr(period_timer_pkg::ADDR_PERIOD, v);
        rd(period_timer_pkg::ADDR_PERIOD, v, "period");
        wr(period_timer_pkg::ADDR_TIMER_CTRL, 8'h00);
        wr(period_timer_pkg::ADDR_TIMER_CNT, v);
        wr(period_timer_pkg::ADDR_TIMER_CTRL, 8'h7B);
        rd(period_timer_pkg::ADDR_TIMER_CNT, v, "count");
        repeat (100) @(posedge i_clk);
        rd(period_timer_pkg::ADDR_TIMER_CNT, v, "count");
        for (k = 0; k < 4; k++)
        begin
            v = {5'h00, 3'($random(seed))};
            wr(period_timer_pkg::ADDR_PERIOD, v);
            wr(period_timer_pkg::ADDR_TIMER_CTRL, {5'h00, 1'b1, 2'(k)});
            // Count may sit above the new period; restart it from zero
            wr(period_timer_pkg::ADDR_TIMER_CNT, 8'h00);
            meas(c);
            meas(c);
            chk("interval", 16'(gap(v, k)), 16'(c));
        end
        // Period 2, no prescale: a match every 12 clocks
        wr(period_timer_pkg::ADDR_PERIOD, 8'h02);
        wr(period_timer_pkg::ADDR_INT_CTRL, 8'hC0);
        wr(period_timer_pkg::ADDR_PERIPH_EN, 8'h02);
        for (k = 0; k < 16; k++)
        begin
            wr(period_timer_pkg::ADDR_TIMER_CTRL, 8'h00);
            wr(period_timer_pkg::ADDR_PERIPH_FLG, 8'h00);
            wr(period_timer_pkg::ADDR_TIMER_CTRL, {1'b0, 4'(k), 3'b100});
            c = 0;
            for (int t = 0; t < 400; t++)
            begin
                @(negedge i_clk);
                if (o_pwm_base)
                    c++;
                if (o_irq)
                    break;
            end
            chk("postscale", 16'(k + 1), 16'(c));
        end
        wr(period_timer_pkg::ADDR_INT_CTRL, 8'h80);
        repeat (2) @(posedge i_clk);
        #1;
        chk("irq masked", 16'h0000, {15'h0000, o_irq});
        rd(period_timer_pkg::ADDR_PERIPH_FLG, 8'h02, "flag");
        // Flag still sets with the peripheral enable and gate bit 6 off (global gate bit 7 still set)
        wr(period_timer_pkg::ADDR_PERIPH_EN, 8'h00);
        wr(period_timer_pkg::ADDR_TIMER_CTRL, 8'h00);
        wr(period_timer_pkg::ADDR_PERIPH_FLG, 8'h00);
        rd(period_timer_pkg::ADDR_PERIPH_FLG, 8'h00, "flag clear");
        wr(period_timer_pkg::ADDR_TIMER_CTRL, 8'h04);
        repeat (40) @(posedge i_clk);
        rd(period_timer_pkg::ADDR_PERIPH_FLG, 8'h02, "flag set");
        chk("irq off", 16'h0000, {15'h0000, o_irq});
        // Reset in mid-run
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(period_timer_pkg::ADDR_TIMER_CNT, 8'h00, "count");
        rd(period_timer_pkg::ADDR_PERIOD, 8'hFF, "period");
        rd(period_timer_pkg::ADDR_TIMER_CTRL, 8'h00, "control");
        rd(period_timer_pkg::ADDR_PERIPH_FLG, 8'h00, "flag");
        test_done();
    end
endmodule
`default_nettype wire
